// ### core/pwesr_pin_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes asynchronous level inputs; pulses last until the next pclk edge with ce high.
`timescale 1ns/1ns
module pwesr_pin_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // Levels in, pulses out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] rise_out
);

    if (W < 1) begin : g_chk
        $error("pwesr_pin_sync: W must be at least 1");
    end

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] lvl_ff;
    logic [W-1:0] agree;
    logic [W-1:0] nxt_lvl;

    // A change counts only when stages two and three agree
    assign agree    = ~(s2_ff ^ s3_ff);
    assign nxt_lvl  = (agree & s3_ff) | (~agree & lvl_ff);
    assign rise_out = nxt_lvl & ~lvl_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            lvl_ff <= '0;
        end else if (ce) begin
            s1_ff  <= pin_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

endmodule : pwesr_pin_sync

// ### core/pwesr_pkg.sv
// Constants and carrier types for the per-port wake and stream tag registers.
// Assumes a 32-bit APB slave where register index = byte address / 4.
package pwesr_pkg;

    // Ports and address layout (index = {port[3:0], offset[11:0]})
    localparam int        N_PORTS  = 3;
    localparam int        ADDR_W   = 18;
    localparam int        EVT_W    = 3;
    localparam int        IRQ_W    = N_PORTS * EVT_W;
    localparam logic [3:0] PORT_MIN = 4'h1;
    localparam logic [3:0] PORT_MAX = 4'h3;
    localparam logic [3:0] PORT_GLB = 4'h0;

    // Per-port register indices
    localparam logic [11:0] OFF_C1_HI = 12'h004;
    localparam logic [11:0] OFF_C1_LO = 12'h005;
    localparam logic [11:0] OFF_C2_HI = 12'h006;
    localparam logic [11:0] OFF_C2_LO = 12'h007;
    localparam logic [11:0] OFF_TYPE1 = 12'h008;
    localparam logic [11:0] OFF_TYPE2 = 12'h00a;
    localparam logic [11:0] OFF_WFLAG = 12'h013;
    localparam logic [11:0] OFF_WEN   = 12'h017;
    // Global interrupt registers, port field zero
    localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h011;

    // Wake event bit positions
    localparam int BIT_MAGIC  = 2;
    localparam int BIT_LINK   = 1;
    localparam int BIT_ENERGY = 0;
    localparam logic [EVT_W-1:0] EVT_ALL = 3'h7;
    localparam logic [EVT_W-1:0] EVT_MAC = 3'h4;

    // Reset values
    localparam logic [7:0]  RST_C1_HI = 8'h60;
    localparam logic [7:0]  RST_C1_LO = 8'h02;
    localparam logic [7:0]  RST_C2_HI = 8'h40;
    localparam logic [7:0]  RST_C2_LO = 8'h03;
    localparam logic [15:0] RST_TYPE  = 16'h88b5;
    localparam logic [EVT_W-1:0] RST_WAKE = 3'h0;
    localparam logic [IRQ_W-1:0] RST_IRQ  = 9'h000;

    // Stream class tag: priority, canonical-format bit, VLAN id
    typedef struct packed {
        logic [2:0]  prio;
        logic        cfi;
        logic [11:0] vid;
    } pwesr_tag_s;

    // Magic packet report from the receive path
    typedef struct packed {
        logic        stb;
        logic [47:0] da;
    } pwesr_magic_s;

endpackage : pwesr_pkg

// ### core/pwesr_regs.sv
// Per-port stream tag and type registers with wake-on-LAN flags, APB slave.
// Assumes magic packet reports and switch MAC on pclk; PHY pins asynchronous.
// What this block does
// RULE1: Each port has a writable class-2 tag high byte (priority, CFI, VID high) reset 0x40.
// RULE2: Each port has a writable class-2 tag low byte with VID bits 7..0, reset 0x03.
// RULE3: Each port has a writable class-1 tag low byte with VID bits 7..0, reset 0x02.
// RULE4: Each port has a 16-bit read/write class-1 layer type, reset 0x88b5.
// RULE5: Each port has a separate 16-bit read/write class-2 layer type, reset 0x88b5.
// RULE6: Flag bit 2 sets only on a magic packet whose destination equals the switch MAC.
// RULE7: Flag bit 1 sets on link up, on PHY ports only.
// RULE8: Flag bit 0 sets on cable energy, on PHY ports only.
// RULE9: With enable bit 2 set, a magic packet detection drives the wake pin.
// RULE10: With enable bit 1 set, a link-up detection on a PHY port drives the wake pin.
// RULE11: With enable bit 0 set, an energy detection on a PHY port drives the wake pin.
// RULE12: Each port has a writable class-1 tag high byte (priority, CFI, VID high) reset 0x60.
// RULE13: Detect flags stay set until a one is written to them; a zero leaves them.
// RULE14: The wake pin is the OR over ports of flags gated by enables, held while any is set.
`timescale 1ns/1ns
module pwesr_regs
    import pwesr_pkg::*;
#(
    parameter int                  NPORT     = N_PORTS,
    parameter logic [N_PORTS-1:0]  PHY_PORTS = 3'b011
) (
    // Clock, reset and freeze
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    ce,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Port event sources
    input  wire pwesr_magic_s [N_PORTS-1:0] magic_rx,
    input  wire logic [47:0]             switch_mac,
    input  wire logic [N_PORTS-1:0]      link_up_pin,
    input  wire logic [N_PORTS-1:0]      energy_pin,
    // Wake and interrupt
    output logic                         wake_event_pin,
    output logic                         irq
);

    if (NPORT != N_PORTS || NPORT > int'(PORT_MAX)) begin : g_chk
        $error("pwesr_regs: NPORT must equal N_PORTS and fit the port field");
    end

    function automatic logic [1:0] slot_of(input logic [3:0] n);
        slot_of = 2'(n - PORT_MIN);
    endfunction : slot_of

    function automatic logic port_off_ok(input logic [11:0] o);
        port_off_ok = (o == OFF_C1_HI) || (o == OFF_C1_LO) || (o == OFF_C2_HI)
                   || (o == OFF_C2_LO) || (o == OFF_TYPE1) || (o == OFF_TYPE2)
                   || (o == OFF_WFLAG) || (o == OFF_WEN);
    endfunction : port_off_ok

    // Register state
    pwesr_tag_s                    c1_ff   [NPORT];
    pwesr_tag_s                    c2_ff   [NPORT];
    logic       [15:0]             t1_ff   [NPORT];
    logic       [15:0]             t2_ff   [NPORT];
    logic [NPORT-1:0][EVT_W-1:0]   flag_ff;
    logic [NPORT-1:0][EVT_W-1:0]   en_ff;
    logic [IRQ_W-1:0]              stat_ff;
    logic [IRQ_W-1:0]              mask_ff;
    logic [31:0]                   prdata_ff;
    logic                          pready_ff;
    logic                          pslverr_ff;
    logic                          wake_ff;
    logic                          irq_ff;

    // Next values
    pwesr_tag_s                    nxt_c1  [NPORT];
    pwesr_tag_s                    nxt_c2  [NPORT];
    logic       [15:0]             nxt_t1  [NPORT];
    logic       [15:0]             nxt_t2  [NPORT];
    logic [NPORT-1:0][EVT_W-1:0]   nxt_flag;
    logic [NPORT-1:0][EVT_W-1:0]   nxt_en;
    logic [NPORT-1:0][EVT_W-1:0]   evt_set;
    logic [IRQ_W-1:0]              nxt_stat;
    logic [31:0]                   port_rd [NPORT];

    // Address decode
    logic [15:0]      idx;
    logic [3:0]       pnum;
    logic [11:0]      offs;
    logic [1:0]       slot;
    logic             port_ok;
    logic             glob_ok;
    logic             map_ok;
    logic             req_go;
    logic             acc_done;
    logic             wr_go;
    logic [31:0]      rd_word;
    logic [NPORT-1:0] lnk_rise;
    logic [NPORT-1:0] nrg_rise;
    logic [NPORT-1:0] mag_hit;
    logic             any_wake;

    assign idx      = paddr[ADDR_W-1:2];
    assign pnum     = idx[15:12];
    assign offs     = idx[11:0];
    assign slot     = slot_of(pnum);
    assign port_ok  = (pnum >= PORT_MIN) && (pnum <= PORT_MAX);
    assign glob_ok  = (pnum == PORT_GLB)
                   && ((offs == OFF_IRQ_STAT) || (offs == OFF_IRQ_MASK));
    assign map_ok   = (port_ok && port_off_ok(offs)) || glob_ok;
    // One wait state: pready rises in the second access cycle
    assign req_go   = psel && penable && !pready_ff;
    assign acc_done = psel && penable && pready_ff;
    assign wr_go    = acc_done && pwrite && map_ok;

    pwesr_pin_sync #(
        .W (2 * NPORT)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .pin_in   ({energy_pin, link_up_pin}),
        .rise_out ({nrg_rise, lnk_rise})
    );

    for (genvar g = 0; g < NPORT; g++) begin : g_port
        logic             sel;
        logic [EVT_W-1:0] avail;
        logic [EVT_W-1:0] clr;

        assign sel   = wr_go && port_ok && (slot == 2'(g));
        // MAC-only port has no link or energy detect
        assign avail = PHY_PORTS[g] ? EVT_ALL : EVT_MAC;
        assign mag_hit[g] = magic_rx[g].stb && (magic_rx[g].da == switch_mac); // [RULE6]
        assign evt_set[g] = {mag_hit[g], lnk_rise[g], nrg_rise[g]} & avail; // [RULE7] [RULE8]
        assign clr   = (sel && offs == OFF_WFLAG) ? pwdata[EVT_W-1:0] : RST_WAKE;
        // Set wins over a clear in the same cycle
        assign nxt_flag[g] = (flag_ff[g] & ~clr) | evt_set[g]; // [RULE13]
        assign nxt_en[g]   = (sel && offs == OFF_WEN) ? (pwdata[EVT_W-1:0] & avail)
                                                      : en_ff[g];
        assign nxt_c1[g] = (sel && offs == OFF_C1_HI) ? {pwdata[7:0], c1_ff[g][7:0]} // [RULE12]
                         : (sel && offs == OFF_C1_LO) ? {c1_ff[g][15:8], pwdata[7:0]} // [RULE3]
                         : c1_ff[g];
        assign nxt_c2[g] = (sel && offs == OFF_C2_HI) ? {pwdata[7:0], c2_ff[g][7:0]} // [RULE1]
                         : (sel && offs == OFF_C2_LO) ? {c2_ff[g][15:8], pwdata[7:0]} // [RULE2]
                         : c2_ff[g];
        assign nxt_t1[g] = (sel && offs == OFF_TYPE1) ? pwdata[15:0] : t1_ff[g]; // [RULE4]
        assign nxt_t2[g] = (sel && offs == OFF_TYPE2) ? pwdata[15:0] : t2_ff[g]; // [RULE5]
        assign port_rd[g] = (offs == OFF_C1_HI) ? 32'(c1_ff[g][15:8])
                          : (offs == OFF_C1_LO) ? 32'(c1_ff[g][7:0])
                          : (offs == OFF_C2_HI) ? 32'(c2_ff[g][15:8])
                          : (offs == OFF_C2_LO) ? 32'(c2_ff[g][7:0])
                          : (offs == OFF_TYPE1) ? 32'(t1_ff[g])
                          : (offs == OFF_TYPE2) ? 32'(t2_ff[g])
                          : (offs == OFF_WFLAG) ? 32'(flag_ff[g])
                          : (offs == OFF_WEN)   ? 32'(en_ff[g])
                          : 32'h0000_0000;
    end

    assign any_wake = |(flag_ff & en_ff); // [RULE9] [RULE10] [RULE11] [RULE14]
    assign nxt_stat = (stat_ff & ~((wr_go && glob_ok && offs == OFF_IRQ_STAT)
                                   ? pwdata[IRQ_W-1:0] : RST_IRQ)) | evt_set;
    assign rd_word  = !map_ok                 ? 32'h0000_0000
                    : port_ok                 ? port_rd[slot]
                    : (offs == OFF_IRQ_STAT)  ? 32'(stat_ff)
                    : 32'(mask_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NPORT; i++) begin
                c1_ff[i] <= pwesr_tag_s'({RST_C1_HI, RST_C1_LO});
                c2_ff[i] <= pwesr_tag_s'({RST_C2_HI, RST_C2_LO});
                t1_ff[i] <= RST_TYPE;
                t2_ff[i] <= RST_TYPE;
            end
            flag_ff <= '0;
            en_ff   <= '0;
        end else if (ce) begin
            for (int i = 0; i < NPORT; i++) begin
                c1_ff[i] <= nxt_c1[i];
                c2_ff[i] <= nxt_c2[i];
                t1_ff[i] <= nxt_t1[i];
                t2_ff[i] <= nxt_t2[i];
            end
            flag_ff <= nxt_flag;
            en_ff   <= nxt_en;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff    <= RST_IRQ;
            mask_ff    <= RST_IRQ;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            wake_ff    <= 1'b0;
            irq_ff     <= 1'b0;
        end else if (ce) begin
            stat_ff    <= nxt_stat;
            mask_ff    <= (wr_go && glob_ok && offs == OFF_IRQ_MASK) ? pwdata[IRQ_W-1:0]
                                                                     : mask_ff;
            prdata_ff  <= (req_go && !pwrite) ? rd_word : prdata_ff;
            pready_ff  <= req_go;
            pslverr_ff <= req_go && !map_ok;
            wake_ff    <= any_wake; // [RULE14]
            irq_ff     <= |(stat_ff & mask_ff);
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign wake_event_pin = wake_ff;
    assign irq            = irq_ff;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [11:0] o);
        wr_go && ce && port_ok && (offs == o);
    endsequence

    sequence s_req;
        psel && !penable && ce ##1 psel && penable && !pready_ff && ce;
    endsequence

    a_apb_one_wait: assert property (s_req |=> pready_ff)
        else $error("pready did not rise one cycle into access");

    a_pready_pulse: assert property (pready_ff && ce |=> !pready_ff)
        else $error("pready held longer than one cycle");

    a_irq_follow: assert property ((|(stat_ff & mask_ff)) && ce |=> irq_ff)
        else $error("irq low with an unmasked status bit");

    a_c2_hi_write: assert property (s_wr(OFF_C2_HI) |=> // [RULE1]
        c2_ff[$past(slot)][15:8] == $past(pwdata[7:0]))
        else $error("class-2 tag high byte not written");

    a_c2_lo_write: assert property (s_wr(OFF_C2_LO) |=> // [RULE2]
        c2_ff[$past(slot)][7:0] == $past(pwdata[7:0]))
        else $error("class-2 tag low byte not written");

    a_c1_lo_write: assert property (s_wr(OFF_C1_LO) |=> // [RULE3]
        c1_ff[$past(slot)][7:0] == $past(pwdata[7:0]))
        else $error("class-1 tag low byte not written");

    a_c1_hi_write: assert property (s_wr(OFF_C1_HI) |=> // [RULE12]
        c1_ff[$past(slot)][15:8] == $past(pwdata[7:0]))
        else $error("class-1 tag high byte not written");

    a_type1_write: assert property (s_wr(OFF_TYPE1) |=> // [RULE4]
        t1_ff[$past(slot)] == $past(pwdata[15:0]))
        else $error("class-1 type not written");

    a_type2_write: assert property (s_wr(OFF_TYPE2) |=> // [RULE5]
        t2_ff[$past(slot)] == $past(pwdata[15:0]))
        else $error("class-2 type not written");

    for (genvar g = 0; g < NPORT; g++) begin : g_chk_port
        a_magic_cause: assert property ($rose(flag_ff[g][BIT_MAGIC]) |-> // [RULE6]
            $past(mag_hit[g]))
            else $error("magic flag set without address match");
        a_link_phy: assert property (lnk_rise[g] && ce |=> // [RULE7]
            flag_ff[g][BIT_LINK] == PHY_PORTS[g])
            else $error("link flag wrong after link-up");
        a_energy_phy: assert property (nrg_rise[g] && ce |=> // [RULE8]
            flag_ff[g][BIT_ENERGY] == PHY_PORTS[g])
            else $error("energy flag wrong after energy detect");
        a_magic_wake: assert property (flag_ff[g][BIT_MAGIC] && en_ff[g][BIT_MAGIC] && ce // [RULE9]
            |=> wake_ff)
            else $error("enabled magic flag did not wake");
        a_link_wake: assert property (flag_ff[g][BIT_LINK] && en_ff[g][BIT_LINK] && ce // [RULE10]
            |=> wake_ff)
            else $error("enabled link flag did not wake");
        a_energy_wake: assert property (flag_ff[g][BIT_ENERGY] && en_ff[g][BIT_ENERGY] // [RULE11]
            && ce |=> wake_ff)
            else $error("enabled energy flag did not wake");
        a_flag_held: assert property (flag_ff[g][BIT_MAGIC] && ce && // [RULE13]
            !(wr_go && port_ok && slot == 2'(g) && offs == OFF_WFLAG
              && pwdata[BIT_MAGIC]) |=> flag_ff[g][BIT_MAGIC])
            else $error("magic flag dropped without write-one");
        a_flag_clear: assert property (wr_go && ce && port_ok && slot == 2'(g) // [RULE13]
            && offs == OFF_WFLAG && pwdata[BIT_MAGIC] && !mag_hit[g]
            |=> !flag_ff[g][BIT_MAGIC])
            else $error("magic flag survived write-one");
        // A detection in the clearing cycle must still leave the flag set
        a_set_wins: assert property (mag_hit[g] && ce |=> flag_ff[g][BIT_MAGIC]) // [RULE6]
            else $error("matched magic packet lost");
        a_mac_no_phy: assert property (!PHY_PORTS[g] |-> // [RULE7] [RULE8]
            (flag_ff[g][BIT_LINK:BIT_ENERGY] | en_ff[g][BIT_LINK:BIT_ENERGY]) == 2'h0)
            else $error("link or energy bit set on MAC-only port");
    end

    a_wake_none: assert property (!any_wake && ce |=> !wake_ff) // [RULE14]
        else $error("wake asserted with no enabled flag");

    // Frozen cycles must hold all state; magic packets arriving while frozen are lost
    a_freeze_state: assert property (!ce |=> $stable(flag_ff) && $stable(en_ff)
        && $stable(stat_ff))
        else $error("state changed while clock enable low");

endmodule : pwesr_regs

// ### testbench/port_wake_event_and_sr_tag_regs_bench.sv
// Self-checking bench for the per-port wake flags and stream tag registers.
// Assumes pwesr_regs and pwesr_evt_model; APB results checked from a note queue.
`timescale 1ns/1ns
module port_wake_event_and_sr_tag_regs_bench;
    import pwesr_pkg::*;
    typedef struct packed {
        logic        wr;
        logic        err;
        logic [31:0] data;
    } pwesr_note_s;
    localparam logic [11:0] OFFS [8] = '{OFF_C1_HI, OFF_C1_LO, OFF_C2_HI, OFF_C2_LO,
                                         OFF_TYPE1, OFF_TYPE2, OFF_WFLAG, OFF_WEN};
    localparam logic [31:0] RSTS [8] = '{32'h60, 32'h02, 32'h40, 32'h03,
                                         32'h88b5, 32'h88b5, 32'h0, 32'h0};
    localparam logic [31:0] MASKS [6] = '{32'hff, 32'hff, 32'hff, 32'hff, 32'hffff, 32'hffff};
    logic                       pclk;
    logic                       presetn;
    logic                       ce;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [ADDR_W-1:0]          paddr;
    logic [31:0]                pwdata;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    pwesr_magic_s [N_PORTS-1:0] magic_rx;
    logic [47:0]                switch_mac;
    logic [N_PORTS-1:0]         link_up_pin;
    logic [N_PORTS-1:0]         energy_pin;
    logic                       wake_event_pin;
    logic                       irq;
    logic [31:0]                rnd;
    pwesr_note_s                q [$];
    pwesr_note_s                nt;
    int                         fails = 0;
    int                         samples_checked = 0;

    pwesr_regs uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .magic_rx(magic_rx), .switch_mac(switch_mac),
        .link_up_pin(link_up_pin), .energy_pin(energy_pin),
        .wake_event_pin(wake_event_pin), .irq(irq));
    pwesr_evt_model evt (.pclk(pclk), .magic_rx(magic_rx), .link_up_pin(link_up_pin),
        .energy_pin(energy_pin));

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [ADDR_W-1:0] adr(input logic [3:0] p, input logic [11:0] o);
        return {p, o, 2'b00};
    endfunction : adr

    task automatic end_sim;
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t read data %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t output bit %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit

    // Expectation queued first; the monitor pairs it with the completion edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        int n;
        q.push_back('{w, ee, ed});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            end_sim;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Bounded wait for wake (sel 0) or irq (sel 1) to reach a level
    task automatic wait_out(input logic sel, input logic exp);
        int n;
        n = 0;
        while (((sel ? irq : wake_event_pin) !== exp) && n < 12) begin
            @(posedge pclk);
            #1;
            n++;
        end
        cmp_bit(sel ? irq : wake_event_pin, exp);
    endtask : wait_out

    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (q.size() == 0) begin
                fails++;
                $display("BAD %0t transfer with no note", $time);
            end else begin
                nt = q.pop_front();
                cmp_bit(pslverr, nt.err);
                if (!nt.wr)
                    cmp_word(prdata, nt.data);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        end_sim;
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rnd        = 32'hd6f23508;
        switch_mac = {rnd[15:0], lfsr(rnd)};
        presetn    = 1'b0;
        ce         = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 1; p <= 3; p++)
            for (int i = 0; i < 8; i++)
                apb(1'b0, adr(p, OFFS[i]), '0, RSTS[i], 1'b0);
        apb(1'b0, adr(0, OFF_IRQ_STAT), '0, '0, 1'b0);
        apb(1'b0, adr(0, OFF_IRQ_MASK), '0, '0, 1'b0);
        $display("test reset values done");
        for (int p = 1; p <= 3; p++)
            for (int i = 0; i < 6; i++) begin
                rnd = lfsr(rnd);
                apb(1'b1, adr(p, OFFS[i]), rnd, '0, 1'b0);
                apb(1'b0, adr(p, OFFS[i]), '0, rnd & MASKS[i], 1'b0);
            end
        apb(1'b1, adr(1, OFF_TYPE1), 32'h1234, '0, 1'b0);
        apb(1'b1, adr(1, 12'h009), 32'hffff_ffff, '0, 1'b1);
        apb(1'b0, adr(1, 12'h00b), '0, '0, 1'b1);
        apb(1'b0, adr(1, OFF_TYPE1), '0, 32'h1234, 1'b0);
        $display("test read back done");
        evt.send_magic(0, ~switch_mac);
        repeat (6) @(posedge pclk);
        apb(1'b0, adr(1, OFF_WFLAG), '0, 32'h0, 1'b0);
        evt.send_magic(0, switch_mac);
        apb(1'b0, adr(1, OFF_WFLAG), '0, 32'h4, 1'b0);
        cmp_bit(wake_event_pin, 1'b0);
        apb(1'b1, adr(0, OFF_IRQ_MASK), 32'h4, '0, 1'b0);
        wait_out(1'b1, 1'b1);
        apb(1'b1, adr(1, OFF_WEN), 32'h4, '0, 1'b0);
        wait_out(1'b0, 1'b1);
        apb(1'b1, adr(1, OFF_WFLAG), 32'h3, '0, 1'b0);
        apb(1'b0, adr(1, OFF_WFLAG), '0, 32'h4, 1'b0);
        cmp_bit(wake_event_pin, 1'b1);
        apb(1'b1, adr(1, OFF_WFLAG), 32'h4, '0, 1'b0);
        apb(1'b0, adr(1, OFF_WFLAG), '0, 32'h0, 1'b0);
        wait_out(1'b0, 1'b0);
        apb(1'b1, adr(0, OFF_IRQ_STAT), 32'h4, '0, 1'b0);
        wait_out(1'b1, 1'b0);
        $display("test magic packet done");
        evt.set_pin(0, 1'b1, 1'b1);
        repeat (8) @(posedge pclk);
        apb(1'b0, adr(1, OFF_WFLAG), '0, 32'h2, 1'b0);
        cmp_bit(wake_event_pin, 1'b0);
        cmp_bit(irq, 1'b0);
        apb(1'b1, adr(1, OFF_WEN), 32'h2, '0, 1'b0);
        wait_out(1'b0, 1'b1);
        apb(1'b1, adr(1, OFF_WEN), 32'h0, '0, 1'b0);
        wait_out(1'b0, 1'b0);
        evt.set_pin(1, 1'b0, 1'b1);
        repeat (8) @(posedge pclk);
        apb(1'b0, adr(2, OFF_WFLAG), '0, 32'h1, 1'b0);
        apb(1'b1, adr(2, OFF_WEN), 32'h1, '0, 1'b0);
        wait_out(1'b0, 1'b1);
        apb(1'b1, adr(2, OFF_WFLAG), 32'h1, '0, 1'b0);
        wait_out(1'b0, 1'b0);
        // Matching packet while frozen must be missed
        @(posedge pclk);
        ce <= 1'b0;
        evt.send_magic(1, switch_mac);
        ce <= 1'b1;
        apb(1'b0, adr(2, OFF_WFLAG), '0, 32'h0, 1'b0);
        $display("test phy pins done");
        evt.set_pin(2, 1'b1, 1'b1);
        evt.set_pin(2, 1'b0, 1'b1);
        repeat (8) @(posedge pclk);
        apb(1'b0, adr(3, OFF_WFLAG), '0, 32'h0, 1'b0);
        apb(1'b1, adr(3, OFF_WEN), 32'h7, '0, 1'b0);
        apb(1'b0, adr(3, OFF_WEN), '0, 32'h4, 1'b0);
        evt.send_magic(2, switch_mac);
        apb(1'b0, adr(3, OFF_WFLAG), '0, 32'h4, 1'b0);
        wait_out(1'b0, 1'b1);
        $display("test mac port done");
        end_sim;
    end
endmodule : port_wake_event_and_sr_tag_regs_bench

// ### testbench/pwesr_evt_model.sv
// Event source model: magic packet reports and PHY level pins driven on pclk.
// Assumes the bench calls its tasks; pins move on the rising edge.
`timescale 1ns/1ns
module pwesr_evt_model
    import pwesr_pkg::*;
(
    // Clock
    input  wire logic                  pclk,
    // Event outputs
    output pwesr_magic_s [N_PORTS-1:0] magic_rx,
    output logic         [N_PORTS-1:0] link_up_pin,
    output logic         [N_PORTS-1:0] energy_pin
);
    initial begin
        magic_rx    = '0;
        link_up_pin = '0;
        energy_pin  = '0;
    end
    // Address inverted after the strobe so a stale match cannot linger
    task automatic send_magic(input int p, input logic [47:0] da);
        @(posedge pclk);
        magic_rx[p].stb <= 1'b1;
        magic_rx[p].da  <= da;
        @(posedge pclk);
        magic_rx[p].stb <= 1'b0;
        magic_rx[p].da  <= ~da;
    endtask : send_magic
    // Design still synchronises these levels as if asynchronous
    task automatic set_pin(input int p, input logic link, input logic v);
        @(posedge pclk);
        if (link)
            link_up_pin[p] <= v;
        else
            energy_pin[p] <= v;
    endtask : set_pin
endmodule : pwesr_evt_model
